/* File: src/clk_stream_regs.svh */
// Register offsets, field positions, reset values and codes
`ifndef CLK_STREAM_REGS_SVH
`define CLK_STREAM_REGS_SVH
`define OFF_CTRL   12'h000
`define OFF_SDIV   12'h004
`define OFF_PDIV   12'h008
`define OFF_STAT   12'h00c
`define CTRL_RST   32'h0000_7015
`define DIV_RST    32'h0ffe_0001
`define F_FMT      1:0
`define F_QUAD     2
`define F_RES      5:3
`define F_SW       7:6
`define F_BBSEL    8
`define F_FEN      9
`define F_SRC      10
`define F_EXT      11
`define F_PBYP     12
`define F_RSCALE   15:13
`define F_TSSEL    18:16
`define F_SERDIV   23:20
`define F_LOW      11:0
`define F_HIGH     27:16
`define FMT_UNS    2'b00
`define FMT_SM     2'b01
`define RES_1      3'b000
`define RES_2      3'b010
`define RES_3      3'b100
`define RS_X2      3'b000
`define RS_D4      3'b001
`define RS_D2      3'b010
`define RS_X1      3'b011
`define RS_X4      3'b100
`define SW_B0      2'b00
`define SW_B01     2'b01
`define SW_B02     2'b10
`define FRAC_BASE  13'h1000
`define SLICE_LAST 4'hf
`define TS_BASE    15'h0080
`endif

/* File: src/clk_stream_pkg.sv */
// Types shared by the sample clock and stream blocks
package clk_stream_pkg;
  typedef logic [2:0] level_t;
  typedef logic [11:0] count_t;
  typedef enum logic [1:0] {
    ST_ZERO  = 2'b01,
    ST_SHIFT = 2'b10
  } ser_state_t;
endpackage

/* File: src/frac_div_if.sv */
// Link between the clock chain and one fractional divider
`timescale 1ns/100ps
`default_nettype none
interface frac_div_if;
  import clk_stream_pkg::*;
  count_t low_count;
  count_t high_count;
  logic   in_tick;
  logic   out_tick;
  modport div  (input low_count, high_count, in_tick, output out_tick);
  modport user (output low_count, high_count, in_tick, input out_tick);
endinterface
`default_nettype wire

/* File: src/frac_divider.sv */
// Fractional tick divider, ratio low / (4096 - high + low)
`timescale 1ns/100ps
`default_nettype none
`include "clk_stream_regs.svh"
module frac_divider (
  input wire logic  clk_sys_in,
  input wire logic  srst_in,
  frac_div_if.div   div_port
);
  import clk_stream_pkg::*;
  logic [12:0] acc;
  wire  [12:0] span = `FRAC_BASE - {1'b0, div_port.high_count}
                      + {1'b0, div_port.low_count};
  wire  [13:0] sum  = {1'b0, acc} + {2'b00, div_port.low_count};
  wire         wrap = (span != 13'h0000) && (sum >= {1'b0, span});
  // Overflow of the accumulator picks floor or ceil period in turn
  wire  [13:0] next_acc = wrap ? sum - {1'b0, span} : sum;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      acc <= 13'h0000;
      div_port.out_tick <= 1'b0;
    end else begin
      if (div_port.in_tick) begin
        acc <= next_acc[12:0];
      end
      div_port.out_tick <= div_port.in_tick & wrap;
    end
  end

  a_acc_bound: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    (span != 13'h0000 && $stable(span)) |=> acc < span)
    else $error("fractional accumulator out of range");
endmodule
`default_nettype wire

/* File: src/sample_clock_stream.sv */
// Sample encoding, clock generation and serial stream output
// What this block does
// - Format 00 unsigned, 01 sign-magnitude, 1x two's complement.
// - Quad enable 0 keeps only I lanes, 1 keeps I and Q except at three-bit resolution (I only).
// - Resolution 000 one bit, 010 two bits, 100 three bits.
// - Two-bit codes per level follow the three format tables.
// - Fractional ratio is low / (4096 - high + low).
// - Fraction comes from alternating adjacent integer periods.
// - Source and fraction bits pick and scale the sampling clock.
// - External enable takes sampling edges from the external pin.
// - I on bit0 and bit1, Q on bit2 and bit3; at three-bit resolution bit2 carries the I LSB.
// - Stream width picks bit0, bit0+1, bit0+2 or all four.
// - Sixteen bits per selected lane in order, then repeat.
// - Four 16-bit holding registers feed four shift registers.
// - Zeros follow the valid bits until the next load.
// - A marker flags the start of each valid slice.
// - Time sync pulses every 128 to 16384 sampling ticks.
// - Crystal pre-divider is fractional, bypassed when select is 1.
// - Reference scale x2, /4, /2, x1 and x4.
// - Baseband clock pin shows scaled reference or sampling clock.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "clk_stream_regs.svh"
module sample_clock_stream (
  input  wire logic                   clk_sys_in,
  input  wire logic                   srst_in,
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [11:0]            paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  input  wire clk_stream_pkg::level_t adc_i_level_in,
  input  wire clk_stream_pkg::level_t adc_q_level_in,
  input  wire logic                   external_sampling_clock_pin_in,
  output logic                        baseband_clock_pin_out,
  output logic      [3:0]             sample_bits_out,
  output logic                        serial_data_out,
  output logic                        serial_clock_out,
  output logic                        slice_start_marker_out,
  output logic                        time_sync_out
);
  import clk_stream_pkg::*;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [31:0] sdiv_reg;
  logic [31:0] pdiv_reg;
  logic [31:0] status;
  wire hit_ctrl = paddr_in == `OFF_CTRL;
  wire hit_sdiv = paddr_in == `OFF_SDIV;
  wire hit_pdiv = paddr_in == `OFF_PDIV;
  wire hit_stat = paddr_in == `OFF_STAT;
  wire mapped   = hit_ctrl | hit_sdiv | hit_pdiv | hit_stat;
  // One wait state: data and error are ready when pready rises
  wire access   = psel_in & penable_in & ~pready_out;
  wire wr_done  = psel_in & penable_in & pready_out & pwrite_in;
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
                       hit_sdiv ? sdiv_reg :
                       hit_pdiv ? pdiv_reg :
                       hit_stat ? status : 32'h0000_0000;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= access;
      pslverr_out <= access & ~mapped;
      prdata_out  <= (access & ~pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl     <= `CTRL_RST;
      sdiv_reg <= `DIV_RST;
      pdiv_reg <= `DIV_RST;
    end else if (wr_done) begin
      if (hit_ctrl) ctrl <= pwdata_in;
      if (hit_sdiv) sdiv_reg <= pwdata_in;
      if (hit_pdiv) pdiv_reg <= pwdata_in;
    end
  end

  wire [1:0] fmt   = ctrl[`F_FMT];
  wire       quad  = ctrl[`F_QUAD];
  wire [2:0] res   = ctrl[`F_RES];
  wire [1:0] sw    = ctrl[`F_SW];
  wire [2:0] rsc   = ctrl[`F_RSCALE];
  wire [3:0] serdv = ctrl[`F_SERDIV];

  // ----------------------------------------
  // Reference chain
  // ----------------------------------------
  // Ticks model clock edges; a bypassed pre-divider ticks every
  // cycle, so the x2 and x4 options need a pre-divided reference.
  frac_div_if pre_if ();
  frac_div_if smp_if ();
  assign pre_if.low_count  = pdiv_reg[`F_LOW];
  assign pre_if.high_count = pdiv_reg[`F_HIGH];
  assign pre_if.in_tick    = 1'b1;
  frac_divider u_pre (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .div_port   (pre_if.div)
  );
  wire ref_tick = ctrl[`F_PBYP] | pre_if.out_tick;

  logic [15:0] pcnt;
  logic [15:0] period;
  logic [15:0] subcnt;
  logic [1:0]  ecnt;
  logic [1:0]  dcnt;
  wire         is_x4   = rsc == `RS_X4;
  wire         is_mul  = is_x4 | (rsc == `RS_X2);
  wire  [15:0] quarter = is_x4 ? period >> 2 : period >> 1;
  wire         extra   = is_mul & (ecnt != 2'b00) & (subcnt == quarter)
                         & (quarter != 16'h0000);
  wire         div_hit = (rsc == `RS_D2) ? dcnt[0] : (dcnt == 2'b11);
  logic        scaled_tick;

  always_comb begin
    case (rsc)
      `RS_X2, `RS_X4: scaled_tick = ref_tick | extra;
      `RS_D2, `RS_D4: scaled_tick = ref_tick & div_hit;
      `RS_X1:         scaled_tick = ref_tick;
      default:        scaled_tick = ref_tick;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pcnt   <= 16'h0000;
      period <= 16'h0000;
      subcnt <= 16'h0000;
      ecnt   <= 2'b00;
      dcnt   <= 2'b00;
    end else if (ref_tick) begin
      pcnt   <= 16'h0001;
      period <= pcnt;
      subcnt <= 16'h0001;
      ecnt   <= is_x4 ? 2'b11 : 2'b01;
      dcnt   <= dcnt + 2'b01;
    end else begin
      pcnt   <= pcnt + 16'h0001;
      subcnt <= extra ? 16'h0001 : subcnt + 16'h0001;
      if (extra) ecnt <= ecnt - 2'b01;
    end
  end

  // ----------------------------------------
  // Sampling clock select
  // ----------------------------------------
  wire samp_src = ctrl[`F_SRC] ? ref_tick : scaled_tick;
  assign smp_if.low_count  = sdiv_reg[`F_LOW];
  assign smp_if.high_count = sdiv_reg[`F_HIGH];
  assign smp_if.in_tick    = samp_src;
  frac_divider u_smp (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .div_port   (smp_if.div)
  );
  wire int_tick = ctrl[`F_FEN] ? smp_if.out_tick : samp_src;
  logic ext_prev;
  wire  ext_rise = external_sampling_clock_pin_in & ~ext_prev;
  wire  sample_tick = ctrl[`F_EXT] ? ext_rise : int_tick;
  wire  bb_tick = ctrl[`F_BBSEL] ? sample_tick : scaled_tick;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ext_prev               <= 1'b0;
      baseband_clock_pin_out <= 1'b0;
    end else begin
      ext_prev <= external_sampling_clock_pin_in;
      if (bb_tick) baseband_clock_pin_out <= ~baseband_clock_pin_out;
    end
  end

  // ----------------------------------------
  // Sample encoding
  // ----------------------------------------
  // Level code 0..7 stands for -7..+7; shorter codes are the top bits
  function automatic logic [2:0] encode(input level_t lv,
                                        input logic [1:0] f);
    logic [2:0] c;
    c = lv;
    if (f[1]) begin
      c = lv ^ 3'h4;
    end else if (f == `FMT_SM) begin
      c = {~lv[2], lv[2] ? lv[1:0] : ~lv[1:0]};
    end
    return c;
  endfunction

  wire [2:0] ci = encode(adc_i_level_in, fmt);
  wire [2:0] cq = encode(adc_q_level_in, fmt);
  wire       r1 = res == `RES_1;
  wire       r3 = res == `RES_3;
  wire [3:0] new_bits = {
    (~r3 & ~r1 & quad) ? cq[1] : 1'b0,
    r3 ? ci[0] : (quad ? cq[2] : 1'b0),
    r1 ? 1'b0 : ci[1],
    ci[2]};

  // ----------------------------------------
  // Holding and shift registers
  // ----------------------------------------
  logic [15:0] hold [4];
  logic [15:0] sh   [4];
  logic [3:0]  hcnt;
  logic [3:0]  bcnt;
  logic [1:0]  pos;
  logic [3:0]  scnt;
  ser_state_t  state;
  wire load     = sample_tick & (hcnt == `SLICE_LAST);
  wire ser_tick = scnt == serdv;

  function automatic logic [1:0] lane_of(input logic [1:0] w,
                                         input logic [1:0] p);
    logic [1:0] l;
    l = p;
    if (w == `SW_B02 && p == 2'b01) l = 2'b10;
    return l;
  endfunction

  function automatic logic [1:0] last_pos(input logic [1:0] w);
    logic [1:0] l;
    l = 2'b11;
    if (w == `SW_B0) l = 2'b00;
    else if (w == `SW_B01 || w == `SW_B02) l = 2'b01;
    return l;
  endfunction

  wire [1:0] lane = lane_of(sw, pos);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hcnt <= 4'h0;
      sample_bits_out <= 4'h0;
    end else if (sample_tick) begin
      hcnt <= hcnt + 4'h1;
      sample_bits_out <= new_bits;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    for (int k = 0; k < 4; k++) begin
      if (srst_in) begin
        hold[k] <= 16'h0000;
      end else if (sample_tick) begin
        hold[k] <= {hold[k][14:0], new_bits[k]};
      end
    end
  end

  // A slow serial clock is overrun by the next load; software sizes it
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= ST_ZERO;
      pos   <= 2'b00;
      bcnt  <= 4'h0;
      scnt  <= 4'h0;
      for (int k = 0; k < 4; k++) sh[k] <= 16'h0000;
    end else begin
      scnt <= ser_tick ? 4'h0 : scnt + 4'h1;
      if (load) begin
        for (int k = 0; k < 4; k++)
          sh[k] <= {hold[k][14:0], new_bits[k]};
        state <= ST_SHIFT;
        pos   <= 2'b00;
        bcnt  <= 4'h0;
      end else if (ser_tick && state == ST_SHIFT) begin
        sh[lane] <= {sh[lane][14:0], 1'b0};
        bcnt     <= bcnt + 4'h1;
        if (bcnt == `SLICE_LAST) begin
          if (pos == last_pos(sw)) state <= ST_ZERO;
          else pos <= pos + 2'b01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      serial_data_out        <= 1'b0;
      serial_clock_out       <= 1'b0;
      slice_start_marker_out <= 1'b0;
    end else begin
      serial_clock_out <= ser_tick & ~load;
      slice_start_marker_out <= ser_tick & ~load & (state == ST_SHIFT)
                                & (bcnt == 4'h0);
      if (ser_tick && !load)
        serial_data_out <= (state == ST_SHIFT) & sh[lane][15];
    end
  end

  // ----------------------------------------
  // Time sync
  // ----------------------------------------
  logic [14:0] tcnt;
  wire  [14:0] tlim = (`TS_BASE << ctrl[`F_TSSEL]) - 15'h0001;
  wire         ts_hit = sample_tick & (tcnt >= tlim);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      tcnt          <= 15'h0000;
      time_sync_out <= 1'b0;
    end else begin
      time_sync_out <= ts_hit;
      if (ts_hit) tcnt <= 15'h0000;
      else if (sample_tick) tcnt <= tcnt + 15'h0001;
    end
  end

  assign status = {20'h00000, state == ST_SHIFT, 1'b0, pos, bcnt, hcnt};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  a_enc_unsigned: assert property (
    (sample_tick && fmt == `FMT_UNS && res == `RES_2)
    |=> {sample_bits_out[0], sample_bits_out[1]}
        == $past(adc_i_level_in[2:1]))
    else $error("unsigned code wrong");
  a_iq_disable: assert property (
    (sample_tick && !quad && !r3) |=> sample_bits_out[3:2] == 2'b00)
    else $error("Q lanes active while disabled");
  a_one_bit_res: assert property (
    (sample_tick && r1) |=> sample_bits_out[3] == 1'b0
    && sample_bits_out[1] == 1'b0)
    else $error("extra bits in one-bit mode");
  a_sm_sign: assert property (
    (sample_tick && fmt == `FMT_SM && res == `RES_2)
    |=> sample_bits_out[0] == !$past(adc_i_level_in[2]))
    else $error("sign bit wrong");
  a_ext_clock: assert property (
    (ctrl[`F_EXT] && !external_sampling_clock_pin_in)
    |-> ##1 !(sample_tick && !external_sampling_clock_pin_in))
    else $error("sample edge without pin edge");
  a_hold_load: assert property (
    load |=> state == ST_SHIFT && bcnt == 4'h0 && pos == 2'b00)
    else $error("load did not start slice");
  a_zero_fill: assert property (
    (state == ST_ZERO && ser_tick && !load) |=> !serial_data_out)
    else $error("data after valid bits");
  a_slice_gap: assert property (
    (slice_start_marker_out && $stable(serdv) && serdv == 4'h0)
    |=> !slice_start_marker_out [*8])
    else $error("slice shorter than sixteen bits");
  a_marker_clock: assert property (
    slice_start_marker_out |-> serial_clock_out ##1 !slice_start_marker_out)
    else $error("marker not one serial cycle");
  a_tsync_gap: assert property (
    time_sync_out |=> !time_sync_out [*8])
    else $error("time sync too frequent");
  a_bb_toggle: assert property (
    (ctrl[`F_BBSEL] && sample_tick)
    |=> baseband_clock_pin_out != $past(baseband_clock_pin_out))
    else $error("baseband pin missed sampling edge");

  c_marker: cover property (slice_start_marker_out);
  c_tsync:  cover property (time_sync_out);
  c_four:   cover property (load && sw == 2'b11);
endmodule
`default_nettype wire

/* File: verif/stream_receiver_model.sv */
// Baseband receiver model that frames the serial sample stream
`timescale 1ns/100ps
`default_nettype none
module stream_receiver_model (
  input  wire logic        clk_sys_in,
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  input  wire logic        marker_in,
  output logic      [15:0] word_out,
  output logic             word_valid_out,
  output logic      [15:0] idle_errors_out
);
  logic [4:0]  bit_count  = 5'h10;
  logic [15:0] shift_word = 16'h0000;
  initial begin
    word_out        = 16'h0000;
    word_valid_out  = 1'b0;
    idle_errors_out = 16'h0000;
  end
  // Bits only count while the serial pulse stands; outside a slice
  // any one bit is an error, so stale data cannot slip through
  always @(posedge clk_sys_in) begin
    word_valid_out <= 1'b0;
    if (serial_clock_in === 1'b1) begin
      if (marker_in === 1'b1) begin
        shift_word <= {15'h0000, serial_data_in};
        bit_count  <= 5'h01;
      end else if (bit_count < 5'h10) begin
        shift_word <= {shift_word[14:0], serial_data_in};
        bit_count  <= bit_count + 5'h01;
        if (bit_count == 5'h0f) begin
          word_out       <= {shift_word[14:0], serial_data_in};
          word_valid_out <= 1'b1;
        end
      end else if (serial_data_in !== 1'b0) begin
        idle_errors_out <= idle_errors_out + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/sample_clock_stream_tb_top.sv */
// Self-checking bench for the sample clock and stream block
`timescale 1ns/100ps
`default_nettype none
module sample_clock_stream_tb_top;
  import clk_stream_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {
    logic [7:0] c;
    level_t     i;
    level_t     q;
    logic [3:0] e;
  } row_t;
  logic        clk_sys, srst, psel, penable, pwrite, ext_pin, er;
  logic        pready, pslverr, bb, sdat, sclk, mark, tsync, wvalid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  level_t      i_lvl, q_lvl;
  logic [3:0]  sbits;
  logic [3:0]  samp[16];
  logic [15:0] word, idle_err, exp_w;
  logic [15:0] words[$];
  int          ts_q[$];
  int          mismatches = 0;
  int          total_checks = 0;
  int          ntick, c, mx, mn, n, lane;
  int          ref_n[5] = '{128, 16, 32, 64, 256};
  // Control low byte (format, quad, resolution), levels, sample bits
  row_t rows[9] = '{'{8'h11, 7, 0, 4'h2}, '{8'h05, 7, 0, 4'h4},
    '{8'h04, 7, 0, 4'h1}, '{8'h06, 0, 7, 4'h1}, '{8'h25, 7, 0, 4'h6},
    '{8'h25, 2, 0, 4'h5}, '{8'h24, 7, 0, 4'h7}, '{8'h26, 0, 0, 4'h1},
    '{8'h27, 3, 0, 4'h7}};

  sample_clock_stream dut_u (
    .clk_sys_in(clk_sys), .srst_in(srst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .adc_i_level_in(i_lvl),
    .adc_q_level_in(q_lvl), .external_sampling_clock_pin_in(ext_pin),
    .baseband_clock_pin_out(bb), .sample_bits_out(sbits),
    .serial_data_out(sdat), .serial_clock_out(sclk),
    .slice_start_marker_out(mark), .time_sync_out(tsync));

  stream_receiver_model rx_u (
    .clk_sys_in(clk_sys), .serial_clock_in(sclk),
    .serial_data_in(sdat), .marker_in(mark), .word_out(word),
    .word_valid_out(wvalid), .idle_errors_out(idle_err));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (wvalid === 1'b1) words.push_back(word);
  always @(posedge clk_sys) if (tsync === 1'b1) ts_q.push_back(ntick);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] code2(logic [1:0] f, level_t l);
    if (f == 2'b00) return l[2:1];
    if (f == 2'b01) return l[2] ? {1'b0, l[1]} : {1'b1, ~l[1]};
    return l[2:1] - 2'd2;
  endfunction
  function automatic logic [3:0] bits2(logic [1:0] f, level_t i,
                                       level_t q);
    logic [1:0] a, b;
    a = code2(f, i);
    b = code2(f, q);
    return {b[0], b[1], a[0], a[1]};
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int w;
    w = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      w++;
    end while (pready !== 1'b1 && w < 40);
    if (w >= 40) mismatches++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
  endtask
  // One external sampling edge, gap cycles long
  task automatic tick(input int gap);
    ext_pin <= 1'b1;
    ntick++;
    repeat (gap / 2) @(posedge clk_sys);
    ext_pin <= 1'b0;
    repeat (gap - gap / 2) @(posedge clk_sys);
  endtask
  task automatic count_bb(input int cyc);
    logic p;
    int g;
    c = 0;
    g = -1;
    mx = 0;
    mn = 999;
    p = bb;
    repeat (cyc) begin
      @(posedge clk_sys);
      if (g >= 0) g++;
      if (bb !== p) begin
        if (g > 0 && g > mx) mx = g;
        if (g > 0 && g < mn) mn = g;
        g = 0;
        c++;
      end
      p = bb;
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #320000;
    mismatches++;
    complete_run();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {srst, psel, penable, pwrite, ext_pin} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    i_lvl = 3'h0;
    q_lvl = 3'h0;
    ntick = 0;
    @(posedge clk_sys);
    do_reset();
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk("ctrl reset", 32'h0000_7015, rd);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk("sdiv reset", 32'h0ffe_0001, rd);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("pdiv reset", 32'h0ffe_0001, rd);
    apb(1'b1, 12'h010, 32'hffff_ffff, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    foreach (rows[r]) begin
      apb(1'b1, 12'h000, 32'h7800 | rows[r].c, rd, er);
      i_lvl <= rows[r].i;
      q_lvl <= rows[r].q;
      tick(10);
      chk("row bits", rows[r].e, sbits);
    end
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, 12'h000, 32'h7814 | f, rd, er);
      for (int l = 0; l < 8; l++) begin
        i_lvl <= 3'(l);
        q_lvl <= 3'(7 - l);
        tick(10);
        chk("two-bit", bits2(2'(f), 3'(l), 3'(7 - l)), sbits);
      end
    end
    for (int s = 0; s < 4; s++) begin
      do_reset();
      apb(1'b1, 12'h000, 32'h7815 | (s << 6), rd, er);
      // Internal ticks before the write moved the holding count; pad
      // to a slice boundary and let that slice drain before counting
      apb(1'b0, 12'h00c, 32'h0, rd, er);
      repeat ((16 - int'(rd[3:0])) % 16) tick(10);
      repeat (80) @(posedge clk_sys);
      words.delete();
      for (int k = 0; k < 16; k++) begin
        i_lvl <= 3'(k);
        q_lvl <= 3'(k * 5);
        samp[k] = bits2(2'b01, 3'(k), 3'(k * 5));
        tick(10);
      end
      repeat (100) @(posedge clk_sys);
      n = (s == 3) ? 4 : (s == 0) ? 1 : 2;
      chk("slice count", n, words.size());
      for (int j = 0; j < n && j < words.size(); j++) begin
        lane = (j == 0) ? 0 : (s == 3) ? j : s;
        for (int k = 0; k < 16; k++) exp_w[15 - k] = samp[k][lane];
        chk("slice word", exp_w, words[j]);
      end
      chk("idle zeros", 0, idle_err);
    end
    // Pre-divide by 32 so that x4 stays inside the clock limits
    do_reset();
    apb(1'b1, 12'h008, 32'h0fe1_0001, rd, er);
    for (int r = 0; r < 5; r++) begin
      apb(1'b1, 12'h000, 32'h0015 | (r << 13), rd, er);
      repeat (64) @(posedge clk_sys);
      count_bb(2048);
      n = ref_n[r];
      chk("ref ticks", n, (c >= n - 2 && c <= n + 2) ? n : c);
    end
    apb(1'b1, 12'h004, 32'h0ff5_0002, rd, er);
    apb(1'b1, 12'h000, 32'h0000_7715, rd, er);
    repeat (64) @(posedge clk_sys);
    count_bb(1300);
    chk("frac ticks", 200, (c >= 198 && c <= 202) ? 200 : c);
    chk("short period", 6, mn);
    chk("long period", 7, mx);
    for (int t = 0; t < 3; t += 2) begin
      do_reset();
      apb(1'b1, 12'h000, 32'h7815 | (t << 16), rd, er);
      ts_q.delete();
      repeat ((128 << t) * 2 + 40) tick(6);
      chk("sync pulses", 1, ts_q.size() >= 2);
      if (ts_q.size() >= 2)
        chk("sync gap", 128 << t, ts_q[1] - ts_q[0]);
    end
    complete_run();
  end
endmodule
`default_nettype wire
